// ==== dsc_pkg.sv ====
// Constants, codes and helpers for the drive switch configuration and brake release block
package dsc_pkg;

  // Clock and LED timing
  localparam int CLK_HZ = 50_000_000;
  localparam int LED_ON_MS = 100;
  localparam int LED_OFF_MS = 300;
  localparam int LED_ON_CYC = CLK_HZ / 1000 * LED_ON_MS;
  localparam int LED_OFF_CYC = CLK_HZ / 1000 * LED_OFF_MS;
  // Must hold the full default period of twenty million cycles; 24 bits would wrap early
  localparam int LED_CNT_W = 25;

  // Switching frequency codes, one-hot
  typedef enum logic [2:0] {
    DSC_PWM_4K = 3'h1,
    DSC_PWM_8K = 3'h2,
    DSC_PWM_16K = 3'h4
  } dsc_pwm_t;

  // Stress levels at which the variable frequency steps down
  localparam logic [1:0] STRESS_TO_8K = 2'h1;
  localparam logic [1:0] STRESS_TO_4K = 2'h2;

  // Bit positions in the synchronised pin vector
  localparam int SY_ADDR = 0;
  localparam int SY_MPDIS = 4;
  localparam int SY_LOWPWR = 5;
  localparam int SY_PWM = 6;
  localparam int SY_DAMP = 7;
  localparam int SY_MTYPE = 8;
  localparam int SY_BRKSW = 9;
  localparam int SY_CW = 10;
  localparam int SY_CCW = 11;
  localparam int SY_SEL = 12;
  localparam int SY_THERMO = 13;
  localparam int SYNC_W = 14;

  // Values after reset, consistent with all synchroniser stages at zero
  localparam logic [SYNC_W-1:0] RST_SYNC = 14'h0000;
  localparam logic [3:0] RST_ADDR = 4'h0;
  localparam logic RST_PROTECT = 1'b1;
  localparam logic RST_OFF = 1'b0;

  // Unit is enabled when exactly one direction terminal is high and no fault
  function automatic logic dsc_enabled(input logic cw, input logic ccw, input logic fault);
    dsc_enabled = (cw ^ ccw) & ~fault;
  endfunction : dsc_enabled

  // Manual brake release condition while not enabled
  function automatic logic dsc_manual(input logic cw, input logic ccw, input logic sel,
                                      input logic fault, input logic brk_sw);
    dsc_manual = ~cw & ~ccw & sel & ~fault & brk_sw;
  endfunction : dsc_manual

  // Frequency policy
  function automatic dsc_pwm_t dsc_pwm(input logic var_sw, input logic [1:0] stress);
    if (!var_sw) begin
      dsc_pwm = DSC_PWM_4K;
    end else if (stress >= STRESS_TO_4K) begin
      dsc_pwm = DSC_PWM_4K;
    end else if (stress >= STRESS_TO_8K) begin
      dsc_pwm = DSC_PWM_8K;
    end else begin
      dsc_pwm = DSC_PWM_16K;
    end
  endfunction : dsc_pwm

endpackage : dsc_pkg

// ==== dsc_led_flasher.sv ====
// Status LED flasher for manual brake release
`timescale 1ns/1ps
module dsc_led_flasher
  import dsc_pkg::*;
#(
  parameter int ON_CYC = LED_ON_CYC,
  parameter int OFF_CYC = LED_OFF_CYC,
  parameter int CNT_W = LED_CNT_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic active,
  output logic led
);

  localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(ON_CYC - 1);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(ON_CYC + OFF_CYC - 1);

  logic [CNT_W-1:0] phase;

  // Phase counter restarts whenever flashing stops, so each burst opens with a full on time
  always_ff @(posedge clock) begin
    if (srst || !active) begin
      phase <= '0;
    end else if (phase == PERIOD_LAST) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // LED lit in the first part of each period
  always_ff @(posedge clock) begin
    if (srst) begin
      led <= 1'b0;
    end else begin
      led <= active && (phase <= ON_LAST);
    end
  end

  property p_led_dark_idle;
    @(posedge clock) disable iff (srst) !active |=> !led;
  endproperty
  a_led_dark_idle: assert property (p_led_dark_idle) else $error("LED lit while idle");

  property p_led_phase;
    @(posedge clock) disable iff (srst)
      active && !$past(srst) |=> led == (($past(phase) <= ON_LAST) && $past(active));
  endproperty
  a_led_phase: assert property (p_led_phase) else $error("LED phase wrong");

  property p_led_first_on;
    @(posedge clock) disable iff (srst) $rose(active) |=> led;
  endproperty
  a_led_first_on: assert property (p_led_first_on) else $error("LED not on at start");

endmodule : dsc_led_flasher

// ==== dsc_config_brake.sv ====
// Switch bank decoder and brake release control
`timescale 1ns/1ps
module dsc_config_brake
  import dsc_pkg::*;
#(
  parameter int FLASH_ON_CYC = LED_ON_CYC,
  parameter int FLASH_OFF_CYC = LED_OFF_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic addr_switch_bit0,
  input wire logic addr_switch_bit1,
  input wire logic addr_switch_bit2,
  input wire logic addr_switch_bit3,
  input wire logic motor_protect_disable_sw,
  input wire logic lower_power_rating_sw,
  input wire logic pwm_freq_select_sw,
  input wire logic noload_damping_sw,
  input wire logic motor_type_sw,
  input wire logic brake_release_no_enable_sw,
  input wire logic cw_terminal,
  input wire logic ccw_terminal,
  input wire logic setpoint_select_terminal,
  input wire logic bimetal_thermostat,
  input wire logic unit_fault,
  input wire logic [1:0] thermal_stress,
  output logic [3:0] unit_address,
  output logic motor_protect_active,
  output logic motor_protect_derated,
  output logic stall_protect_active,
  output logic thermostat_trip,
  output dsc_pwm_t pwm_freq_code,
  output logic noload_damping_active,
  output logic motor_type_special,
  output logic unit_enabled,
  output logic setpoint_two_active,
  output logic brake_release,
  output logic brake_manual_release,
  output logic status_led_flash
);

  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] meta;
  logic [SYNC_W-1:0] sy;
  logic next_enabled;
  logic next_manual;

  // Pin gathering; every switch and terminal is asynchronous to the clock
  assign pins = {bimetal_thermostat, setpoint_select_terminal, ccw_terminal, cw_terminal,
                 brake_release_no_enable_sw, motor_type_sw, noload_damping_sw,
                 pwm_freq_select_sw, lower_power_rating_sw, motor_protect_disable_sw,
                 addr_switch_bit3, addr_switch_bit2, addr_switch_bit1, addr_switch_bit0};

  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge clock) begin
    if (srst) begin
      meta <= RST_SYNC;
      sy <= RST_SYNC;
    end else begin
      meta <= pins;
      sy <= meta;
    end
  end

  // Enable and manual release decode from synchronised terminals
  assign next_enabled = dsc_enabled(sy[SY_CW], sy[SY_CCW], unit_fault);
  assign next_manual = dsc_manual(sy[SY_CW], sy[SY_CCW], sy[SY_SEL], unit_fault,
                                  sy[SY_BRKSW]);

  // Bus unit address; the switch position is the binary weight
  always_ff @(posedge clock) begin
    if (srst) begin
      unit_address <= RST_ADDR;
    end else begin
      unit_address <= sy[SY_ADDR +: 4];
    end
  end

  // Motor protection policy; current limit is deliberately not touched by the rating switch
  always_ff @(posedge clock) begin
    if (srst) begin
      motor_protect_active <= RST_PROTECT;
      motor_protect_derated <= RST_OFF;
      stall_protect_active <= RST_PROTECT;
      thermostat_trip <= RST_OFF;
    end else begin
      motor_protect_active <= ~sy[SY_MPDIS];
      motor_protect_derated <= sy[SY_LOWPWR];
      stall_protect_active <= ~sy[SY_LOWPWR];
      // Near-motor mounting relies on the thermostat opening its loop
      thermostat_trip <= sy[SY_MPDIS] & ~sy[SY_THERMO];
    end
  end

  // Switching frequency; stress input is from on-clock logic and is not synchronised
  always_ff @(posedge clock) begin
    if (srst) begin
      pwm_freq_code <= DSC_PWM_4K;
    end else begin
      pwm_freq_code <= dsc_pwm(sy[SY_PWM], thermal_stress);
    end
  end

  // Plain mode bits; motor type is passed on, correct setting is the installer's duty
  always_ff @(posedge clock) begin
    if (srst) begin
      noload_damping_active <= RST_OFF;
      motor_type_special <= RST_OFF;
    end else begin
      noload_damping_active <= sy[SY_DAMP];
      motor_type_special <= sy[SY_MTYPE];
    end
  end

  // Enable, setpoint and brake; fault forces applied through both decode functions
  always_ff @(posedge clock) begin
    if (srst) begin
      unit_enabled <= RST_OFF;
      setpoint_two_active <= RST_OFF;
      brake_release <= RST_OFF;
      brake_manual_release <= RST_OFF;
    end else begin
      unit_enabled <= next_enabled;
      setpoint_two_active <= next_enabled & sy[SY_SEL];
      brake_release <= next_enabled | next_manual;
      brake_manual_release <= next_manual;
    end
  end

  // Flasher follows the registered manual state, so LED lags by one cycle
  dsc_led_flasher #(
    .ON_CYC(FLASH_ON_CYC),
    .OFF_CYC(FLASH_OFF_CYC),
    .CNT_W(LED_CNT_W)
  ) u_flash (
    .clock(clock),
    .srst(srst),
    .active(brake_manual_release),
    .led(status_led_flash)
  );

  property p_addr;
    @(posedge clock) disable iff (srst)
      !$past(srst, 3) && !$past(srst, 2) && !$past(srst) |->
      unit_address == {$past(addr_switch_bit3, 3), $past(addr_switch_bit2, 3),
                       $past(addr_switch_bit1, 3), $past(addr_switch_bit0, 3)};
  endproperty
  a_addr: assert property (p_addr) else $error("Address not the switch value");

  property p_lowpwr;
    @(posedge clock) disable iff (srst)
      !$past(srst, 3) && !$past(srst, 2) && !$past(srst) |->
      stall_protect_active == !$past(lower_power_rating_sw, 3);
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("Stall protection with lower rating");

  property p_derate;
    @(posedge clock) disable iff (srst)
      !$past(srst) |-> motor_protect_derated == $past(sy[SY_LOWPWR]);
  endproperty
  a_derate: assert property (p_derate) else $error("Derate not following switch");

  property p_protect;
    @(posedge clock) disable iff (srst)
      !$past(srst) |-> motor_protect_active == !$past(sy[SY_MPDIS]);
  endproperty
  a_protect: assert property (p_protect) else $error("Protection state wrong");

  property p_pwm_fixed;
    @(posedge clock) disable iff (srst)
      !$past(srst) && !$past(sy[SY_PWM]) |-> pwm_freq_code == DSC_PWM_4K;
  endproperty
  a_pwm_fixed: assert property (p_pwm_fixed) else $error("Not 4 kHz with switch off");

  property p_pwm_var;
    @(posedge clock) disable iff (srst)
      !$past(srst) && $past(sy[SY_PWM]) && $past(thermal_stress) == 2'h0 |->
      pwm_freq_code == DSC_PWM_16K;
  endproperty
  a_pwm_var: assert property (p_pwm_var) else $error("Not 16 kHz when cool");

  property p_damp;
    @(posedge clock) disable iff (srst)
      !$past(srst) |-> noload_damping_active == $past(sy[SY_DAMP]);
  endproperty
  a_damp: assert property (p_damp) else $error("Damping not following switch");

  property p_fault;
    @(posedge clock) disable iff (srst)
      unit_fault && !srst |=> !brake_release && !unit_enabled;
  endproperty
  a_fault: assert property (p_fault) else $error("Brake released under fault");

  property p_enable;
    @(posedge clock) disable iff (srst)
      !$past(srst) |-> unit_enabled == (($past(sy[SY_CW]) ^ $past(sy[SY_CCW]))
                                        && !$past(unit_fault));
  endproperty
  a_enable: assert property (p_enable) else $error("Enable decode wrong");

  property p_both_high;
    @(posedge clock) disable iff (srst)
      !$past(srst) && $past(sy[SY_CW]) && $past(sy[SY_CCW]) |-> !brake_release;
  endproperty
  a_both_high: assert property (p_both_high) else $error("Released with both high");

  property p_manual;
    @(posedge clock) disable iff (srst)
      !$past(srst) |-> brake_manual_release == (!$past(sy[SY_CW]) && !$past(sy[SY_CCW])
        && $past(sy[SY_SEL]) && !$past(unit_fault) && $past(sy[SY_BRKSW]));
  endproperty
  a_manual: assert property (p_manual) else $error("Manual release decode wrong");

  property p_need_sw;
    @(posedge clock) disable iff (srst)
      !$past(srst) && !$past(sy[SY_BRKSW]) && !unit_enabled |-> !brake_release;
  endproperty
  a_need_sw: assert property (p_need_sw) else $error("Released without switch");

  cover property (@(posedge clock) disable iff (srst) brake_manual_release ##1 status_led_flash);
  cover property (@(posedge clock) disable iff (srst) unit_enabled && setpoint_two_active);
  cover property (@(posedge clock) disable iff (srst) pwm_freq_code == DSC_PWM_8K);
  cover property (@(posedge clock) disable iff (srst) unit_enabled ##1 !unit_enabled);

endmodule : dsc_config_brake

// ==== dsc_terminal_model.sv ====
// Binary control terminal model: direction, setpoint select and address switches
`timescale 1ns/1ps
module dsc_terminal_model (
  input wire logic clock,
  input wire logic [2:0] cmd,
  input wire logic bin_mode,
  input wire logic [3:0] addr_req,
  output logic cw_terminal,
  output logic ccw_terminal,
  output logic setpoint_select_terminal,
  output logic [3:0] addr_pins
);
  // Terminals change just after an edge, like a controller output card
  always_ff @(posedge clock) begin
    cw_terminal <= cmd[2];
    ccw_terminal <= cmd[1];
    setpoint_select_terminal <= cmd[0];
  end
  // Terminal wiring needs address zero; a bus master never uses zero, so zero becomes one
  assign addr_pins = bin_mode ? 4'h0 : ((addr_req == 4'h0) ? 4'h1 : addr_req);
  // Keypad and plain fieldbus sit at one, a general master anywhere from one up
endmodule : dsc_terminal_model

// ==== dsc_config_brake_tb.sv ====
// Self-checking bench for the switch decoder and brake release block
`timescale 1ns/1ps
module dsc_config_brake_tb;
  import dsc_pkg::*;
  localparam int ON_C = 4;
  localparam int OFF_C = 12;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr_req = 4'h0;
  logic bin_mode = 1'b1;
  // The load is a travel axis, not a hoist, so release without enable may be tried
  localparam bit HOIST = 1'b0;
  int led_q[$];
  logic [5:0] sw = 6'h00; // {brk, mtype, damp, pwm, lowpwr, mpdis}
  logic [2:0] cmd = 3'h0;
  logic thermo = 1'b0;
  logic fault = 1'b0;
  logic [1:0] stress = 2'h0;
  logic cw, ccw, sel;
  logic [3:0] addr_pins;
  logic [3:0] unit_address;
  logic mp_act, derated, stall, trip, damp, mtype, en, sp2, brake, manual, led;
  dsc_pwm_t pwm_code;
  int err_count = 0;
  int n_checks = 0;

  // Free-running 50 MHz clock
  initial begin
    forever #10 clock = ~clock;
  end

  dsc_terminal_model i_dsc_terminal_model (.clock(clock), .cmd(cmd), .bin_mode(bin_mode),
    .addr_req(addr_req), .cw_terminal(cw), .ccw_terminal(ccw),
    .setpoint_select_terminal(sel), .addr_pins(addr_pins));

  // Short flash counts keep the run brief
  dsc_config_brake #(.FLASH_ON_CYC(ON_C), .FLASH_OFF_CYC(OFF_C)) i_dsc_config_brake (
    .clock(clock), .srst(srst), .addr_switch_bit0(addr_pins[0]),
    .addr_switch_bit1(addr_pins[1]), .addr_switch_bit2(addr_pins[2]),
    .addr_switch_bit3(addr_pins[3]), .motor_protect_disable_sw(sw[0]),
    .lower_power_rating_sw(sw[1]), .pwm_freq_select_sw(sw[2]), .noload_damping_sw(sw[3]),
    .motor_type_sw(sw[4]), .brake_release_no_enable_sw(sw[5]), .cw_terminal(cw),
    .ccw_terminal(ccw), .setpoint_select_terminal(sel), .bimetal_thermostat(thermo),
    .unit_fault(fault), .thermal_stress(stress), .unit_address(unit_address),
    .motor_protect_active(mp_act), .motor_protect_derated(derated),
    .stall_protect_active(stall), .thermostat_trip(trip), .pwm_freq_code(pwm_code),
    .noload_damping_active(damp), .motor_type_special(mtype), .unit_enabled(en),
    .setpoint_two_active(sp2), .brake_release(brake), .brake_manual_release(manual),
    .status_led_flash(led));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Reference model in integers, worked out from the switch and terminal meanings
  task automatic compare_all();
    int a, e, m, p;
    a = bin_mode ? 0 : ((addr_req == 0) ? 1 : addr_req);
    e = (cmd[2] != cmd[1]) && !fault;
    m = !cmd[2] && !cmd[1] && cmd[0] && !fault && sw[5];
    if (!sw[2] || stress >= 2) begin
      p = DSC_PWM_4K;
    end else if (stress == 1) begin
      p = DSC_PWM_8K;
    end else begin
      p = DSC_PWM_16K;
    end
    check("unit_address", 8'(unit_address), 8'(a));
    check("protect", 8'(mp_act), 8'(!sw[0]));
    check("derated", 8'(derated), 8'(sw[1]));
    check("stall", 8'(stall), 8'(!sw[1]));
    check("trip", 8'(trip), 8'(sw[0] && !thermo));
    check("pwm", 8'(pwm_code), 8'(p));
    check("damping", 8'(damp), 8'(sw[3]));
    check("motor_type", 8'(mtype), 8'(sw[4]));
    check("enabled", 8'(en), 8'(e));
    check("setpoint_two", 8'(sp2), 8'(e && cmd[0]));
    check("brake", 8'(brake), 8'(e || m));
    check("manual", 8'(manual), 8'(m));
  endtask : compare_all

  // Main sequence: reset, random sweep, flash pattern, fault abort
  initial begin
    int k;
    void'($urandom(7164));
    repeat (15) @(posedge clock);
    @(negedge clock);
    compare_all();
    @(posedge clock);
    srst <= 1'b0;
    // Pins take up to four edges through the model, synchroniser and output registers
    for (int i = 0; i < 200; i++) begin
      @(posedge clock);
      addr_req <= 4'(i);
      bin_mode <= 1'($urandom);
      sw <= 6'($urandom) & {!HOIST, 5'h1F};
      cmd <= 3'($urandom);
      thermo <= 1'($urandom);
      fault <= 1'($urandom);
      stress <= 2'($urandom);
      repeat (6) @(posedge clock);
      @(negedge clock);
      compare_all();
    end
    // Park both directions and select low first; a release left by the sweep would skew the LED
    @(posedge clock);
    cmd <= 3'h0;
    sw <= {!HOIST, 5'h00};
    fault <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    compare_all();
    // Manual release: select high with the release switch on
    @(posedge clock);
    cmd <= 3'h1;
    for (int j = 0; j < 2 * (ON_C + OFF_C); j++) begin
      led_q.push_back((j % (ON_C + OFF_C)) < ON_C);
    end
    k = 0;
    while (manual !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    if (k >= 20) begin
      err_count++;
    end else begin
      // Two full periods of the on/off pattern
      while (led_q.size() > 0) begin
        @(negedge clock);
        check("led", 8'(led), 8'(led_q.pop_front()));
      end
    end
    // A fault in mid-flash drops the release and the light
    @(posedge clock);
    fault <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    compare_all();
    check("led_off", 8'(led), 8'h00);
    wrap_up();
  end
endmodule : dsc_config_brake_tb
